// >>> include/dso_defs.svh
// Purpose: Constants for the drive status output block.
// Assumes: Frequencies are in 0.1 Hz steps, percentages in 1 % steps.
// Notes:   Terminal codes above 100 select the inverted form of a flag.
`ifndef DSO_DEFS_SVH
`define DSO_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DSO_CLK_MHZ         125
`define DSO_REGEN_HOLD_MS   100

// ----------------------------------------------------------------
// Settings and defaults
// ----------------------------------------------------------------
`define DSO_FREQ_W          16
`define DSO_SAME_AS_FIRST   16'h270F
`define DSO_PCT_SCALE       24'h000064
`define DSO_NEG_OFFSET      8'h64

// ----------------------------------------------------------------
// Terminal function codes, positive logic
// ----------------------------------------------------------------
`define DSO_CODE_OFD1       8'h04
`define DSO_CODE_OFD2       8'h05
`define DSO_CODE_OFD3       8'h06
`define DSO_CODE_AT_TARGET  8'h01
`define DSO_CODE_FWD        8'h1E
`define DSO_CODE_REV        8'h1F
`define DSO_CODE_REGEN      8'h20
`define DSO_CODE_SLOW       8'h22
`define DSO_CODE_SPD1       8'h29
`define DSO_CODE_SPD2       8'h2A
`define DSO_CODE_SPD3       8'h2B
`define DSO_CODE_SHUT       8'h5B
`define DSO_CODE_ALARM2     8'h5E

`endif

// >>> include/dso_pkg.sv
// Purpose: Types for the drive status output block.
// Assumes: Constants come from dso_defs.svh.
// Notes:   Alarm codes are local numbering, not display codes.
package dso_pkg;

	typedef enum logic [1:0] {
		DSO_CTRL_VF,
		DSO_CTRL_ADV_FLUX,
		DSO_CTRL_SENSORLESS,
		DSO_CTRL_VECTOR
	} dso_ctrl_t;

	typedef enum logic [4:0] {
		DSO_FLT_NONE,
		DSO_FLT_INRUSH,
		DSO_FLT_CPU_A,
		DSO_FLT_CPU_B,
		DSO_FLT_CPU_C,
		DSO_FLT_PARAM_A,
		DSO_FLT_PARAM_B,
		DSO_FLT_AUX_SHORT,
		DSO_FLT_PANEL_SHORT,
		DSO_FLT_GROUND,
		DSO_FLT_PHASE_LOSS,
		DSO_FLT_BRAKE_TR,
		DSO_FLT_OTHER
	} dso_alarm_t;

	typedef enum logic [1:0] {
		DSO_ALST_IDLE,
		DSO_ALST_TRIPPED,
		DSO_ALST_RESETTING
	} dso_alst_t;

endpackage

// >>> rtl/dso_top.sv
// Purpose: Drive status flags and their routing to output terminals.
// Assumes: All inputs are synchronous to clock, driven by on-chip logic.
// Notes:   Frequencies are unsigned magnitudes in 0.1 Hz steps.
`timescale 1ns/100ps
`include "dso_defs.svh"

// Operation
// - regen flag high while motor regenerates
// - regen flag held at least 100 ms
// - regen flag low when stopped or pre-exciting
// - regen flag on codes 32 / 132
// - direction and regen flags only in vector
// - direction flags off while drive stopped
// - alarm stop raises both alarm flags
// - secondary alarm stays on during reset
// - secondary alarm on codes 94 / 194
// - relay contact shows primary alarm by default
// - contactor shutoff for eleven circuit-failure alarms
// - contactor shutoff on codes 91 / 191
// - at-target flag within percent band
// - detect flag 1 at threshold 1
// - reverse threshold unless 9999
// - output versus actual-speed comparisons
// - both flag forms together in V/F, flux
// - detect flag 2 at threshold 2
// - detect flag 3 at threshold 3
// - low-speed threshold setting
// - detection flags on their terminal codes
// - low-speed flag below its threshold
// - frequency flags off in brake, pre-excite, tuning
module dso_top #(
	parameter int unsigned REGEN_HOLD_CYC =
		`DSO_REGEN_HOLD_MS * 1000 * `DSO_CLK_MHZ
) (
	input  wire logic               clock,                    // System clock
	input  wire logic               arst_n,                   // Async reset
	input  wire logic [1:0]         control_method,           // dso_ctrl_t
	input  wire logic               drive_stopped,            // No output
	input  wire logic               pre_excite,               // Pre-excitation
	input  wire logic               dc_brake,                 // DC injection
	input  wire logic               start_tuning,             // Start tuning
	input  wire logic               regen_cond,               // Regenerating
	input  wire logic               reverse_dir,              // Reverse turn
	input  wire logic               alarm_stop,               // Alarm stop
	input  wire logic [4:0]         alarm_code,               // dso_alarm_t
	input  wire logic               reset_active,             // Reset period
	input  wire logic [15:0]        output_freq,              // 0.1 Hz
	input  wire logic [15:0]        set_freq,                 // 0.1 Hz
	input  wire logic [15:0]        motor_speed,              // 0.1 Hz
	input  wire logic [6:0]         target_band_percent,      // 0..100
	input  wire logic [15:0]        detect_threshold_1,       // 0.1 Hz
	input  wire logic [15:0]        reverse_detect_threshold, // 0.1 Hz
	input  wire logic [15:0]        detect_threshold_2,       // 0.1 Hz
	input  wire logic [15:0]        detect_threshold_3,       // 0.1 Hz
	input  wire logic [15:0]        low_speed_threshold,      // 0.1 Hz
	input  wire logic [55:0]        terminal_function_codes,  // 7 x 8 bits
	input  wire logic               relay_assign_en,          // Relay by code
	input  wire logic [7:0]         relay_function_code,      // Relay code
	output logic [6:0]              terminal_out_q,           // Terminals
	output logic                    changeover_relay_contact, // Relay
	output logic                    regen_status_flag,        // Regenerating
	output logic                    forward_rotation_flag,    // Forward
	output logic                    reverse_rotation_flag,    // Reverse
	output logic                    primary_alarm_flag,       // Alarm
	output logic                    secondary_alarm_flag,     // Alarm, reset
	output logic                    input_contactor_shutoff_flag, // Shutoff
	output logic                    at_target_frequency_flag, // Up to freq
	output logic                    output_freq_detect_flag_1, // Freq 1
	output logic                    output_freq_detect_flag_2, // Freq 2
	output logic                    output_freq_detect_flag_3, // Freq 3
	output logic                    speed_detect_flag_1,      // Speed 1
	output logic                    speed_detect_flag_2,      // Speed 2
	output logic                    speed_detect_flag_3,      // Speed 3
	output logic                    low_speed_flag            // Low speed
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic fdet(
		input logic [15:0] f,
		input logic [15:0] thr
	);
		fdet = (f >= thr);
	endfunction

	// Selects one flag by function code; unknown codes read as off.
	function automatic logic pick(
		input logic [7:0]  code,
		input logic [12:0] fl
	);
		logic [7:0] c;
		logic       neg;
		logic       v;
		c   = code;
		neg = 1'b0;
		v   = 1'b0;
		if (code >= `DSO_NEG_OFFSET) begin
			c   = code - `DSO_NEG_OFFSET;
			neg = 1'b1;
		end
		case (c)
			`DSO_CODE_REGEN:     v = fl[0];
			`DSO_CODE_FWD:       v = fl[1];
			`DSO_CODE_REV:       v = fl[2];
			`DSO_CODE_ALARM2:    v = fl[3];
			`DSO_CODE_SHUT:      v = fl[4];
			`DSO_CODE_AT_TARGET: v = fl[5];
			`DSO_CODE_OFD1:      v = fl[6];
			`DSO_CODE_SPD1:      v = fl[7];
			`DSO_CODE_OFD2:      v = fl[8];
			`DSO_CODE_SPD2:      v = fl[9];
			`DSO_CODE_OFD3:      v = fl[10];
			`DSO_CODE_SPD3:      v = fl[11];
			`DSO_CODE_SLOW:      v = fl[12];
			default:             return 1'b0;
		endcase
		pick = v ^ neg;
	endfunction

	// ----------------------------------------------------------------
	// Operating state decode
	// ----------------------------------------------------------------
	logic vector_mode;
	logic open_loop;
	logic inhibit;
	logic [15:0] speed_cmp;

	assign vector_mode = (control_method == dso_pkg::DSO_CTRL_VECTOR);
	assign open_loop   = (control_method == dso_pkg::DSO_CTRL_VF) ||
	                     (control_method == dso_pkg::DSO_CTRL_ADV_FLUX);
	assign inhibit     = dc_brake || pre_excite || start_tuning;
	assign speed_cmp   = open_loop ? output_freq : motor_speed;

	// ----------------------------------------------------------------
	// Regenerative status with minimum hold
	// ----------------------------------------------------------------
	logic [31:0] regen_cnt_q;
	logic        regen_q;
	logic        regen_ok;

	assign regen_ok = vector_mode && !drive_stopped && !pre_excite;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			regen_q     <= 1'b0;
			regen_cnt_q <= 32'h00000000;
		end else if (!regen_ok) begin
			regen_q     <= 1'b0;
			regen_cnt_q <= 32'h00000000;
		end else if (regen_cond) begin
			regen_q     <= 1'b1;
			regen_cnt_q <= REGEN_HOLD_CYC - 32'h00000001;
		end else if (regen_cnt_q != 32'h00000000) begin
			regen_cnt_q <= regen_cnt_q - 32'h00000001;
		end else begin
			regen_q     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Rotation direction
	// ----------------------------------------------------------------
	logic fwd_d;
	logic rev_d;
	logic turning;

	assign turning = (motor_speed != 16'h0000);
	assign fwd_d = regen_ok && turning && !reverse_dir;
	assign rev_d = regen_ok && turning && reverse_dir;

	// ----------------------------------------------------------------
	// Alarm sequencing
	// ----------------------------------------------------------------
	dso_pkg::dso_alst_t alst_q;
	logic               shut_class;

	// Keeps the secondary alarm through the reset period after a trip.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			alst_q <= dso_pkg::DSO_ALST_IDLE;
		end else begin
			case (alst_q)
				dso_pkg::DSO_ALST_IDLE: begin
					if (alarm_stop) begin
						alst_q <= dso_pkg::DSO_ALST_TRIPPED;
					end
				end
				dso_pkg::DSO_ALST_TRIPPED: begin
					if (reset_active) begin
						alst_q <= dso_pkg::DSO_ALST_RESETTING;
					end else if (!alarm_stop) begin
						alst_q <= dso_pkg::DSO_ALST_IDLE;
					end
				end
				dso_pkg::DSO_ALST_RESETTING: begin
					if (!reset_active) begin
						alst_q <= alarm_stop ? dso_pkg::DSO_ALST_TRIPPED
						                     : dso_pkg::DSO_ALST_IDLE;
					end
				end
				default: alst_q <= dso_pkg::DSO_ALST_IDLE;
			endcase
		end
	end

	always_comb begin
		case (dso_pkg::dso_alarm_t'(alarm_code))
			dso_pkg::DSO_FLT_INRUSH,
			dso_pkg::DSO_FLT_CPU_A,
			dso_pkg::DSO_FLT_CPU_B,
			dso_pkg::DSO_FLT_CPU_C,
			dso_pkg::DSO_FLT_PARAM_A,
			dso_pkg::DSO_FLT_PARAM_B,
			dso_pkg::DSO_FLT_AUX_SHORT,
			dso_pkg::DSO_FLT_PANEL_SHORT,
			dso_pkg::DSO_FLT_GROUND,
			dso_pkg::DSO_FLT_PHASE_LOSS,
			dso_pkg::DSO_FLT_BRAKE_TR: shut_class = 1'b1;
			default:                   shut_class = 1'b0;
		endcase
	end

	logic alarm1_d;
	logic alarm2_d;
	logic shut_d;

	assign alarm1_d = alarm_stop;
	assign alarm2_d = alarm_stop ||
	                  (alst_q == dso_pkg::DSO_ALST_RESETTING) ||
	                  ((alst_q == dso_pkg::DSO_ALST_TRIPPED) && reset_active);
	assign shut_d = alarm_stop && shut_class;

	// ----------------------------------------------------------------
	// Frequency detection
	// ----------------------------------------------------------------
	logic [15:0] thr1;
	logic [15:0] fdiff;
	logic [23:0] band_lhs;
	logic [23:0] band_rhs;
	logic        band_d;
	logic        ofd1_d;
	logic        ofd2_d;
	logic        ofd3_d;
	logic        spd1_d;
	logic        spd2_d;
	logic        spd3_d;
	logic        slow_d;

	assign thr1 = (reverse_dir &&
	               reverse_detect_threshold != `DSO_SAME_AS_FIRST) ?
	              reverse_detect_threshold : detect_threshold_1;

	assign fdiff    = (output_freq >= set_freq) ? output_freq - set_freq
	                                            : set_freq - output_freq;
	// Cross-multiplied so no divider is needed for the band test.
	assign band_lhs = 24'(fdiff) * `DSO_PCT_SCALE;
	assign band_rhs = 24'(set_freq) * 24'(target_band_percent);

	assign band_d = !inhibit && (band_lhs <= band_rhs);
	assign ofd1_d = !inhibit && fdet(output_freq, thr1);
	assign spd1_d = !inhibit && fdet(speed_cmp, thr1);
	assign ofd2_d = !inhibit && fdet(output_freq, detect_threshold_2);
	assign spd2_d = !inhibit && fdet(speed_cmp, detect_threshold_2);
	assign ofd3_d = !inhibit && fdet(output_freq, detect_threshold_3);
	assign spd3_d = !inhibit && fdet(speed_cmp, detect_threshold_3);
	assign slow_d = !inhibit && !fdet(output_freq, low_speed_threshold);

	// ----------------------------------------------------------------
	// Flag registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			forward_rotation_flag        <= 1'b0;
			reverse_rotation_flag        <= 1'b0;
			regen_status_flag            <= 1'b0;
			primary_alarm_flag           <= 1'b0;
			secondary_alarm_flag         <= 1'b0;
			input_contactor_shutoff_flag <= 1'b0;
		end else begin
			forward_rotation_flag        <= fwd_d;
			reverse_rotation_flag        <= rev_d;
			regen_status_flag            <= regen_q;
			primary_alarm_flag           <= alarm1_d;
			secondary_alarm_flag         <= alarm2_d;
			input_contactor_shutoff_flag <= shut_d;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			at_target_frequency_flag  <= 1'b0;
			output_freq_detect_flag_1 <= 1'b0;
			output_freq_detect_flag_2 <= 1'b0;
			output_freq_detect_flag_3 <= 1'b0;
			speed_detect_flag_1       <= 1'b0;
			speed_detect_flag_2       <= 1'b0;
			speed_detect_flag_3       <= 1'b0;
			low_speed_flag            <= 1'b0;
		end else begin
			at_target_frequency_flag  <= band_d;
			output_freq_detect_flag_1 <= ofd1_d;
			output_freq_detect_flag_2 <= ofd2_d;
			output_freq_detect_flag_3 <= ofd3_d;
			speed_detect_flag_1       <= spd1_d;
			speed_detect_flag_2       <= spd2_d;
			speed_detect_flag_3       <= spd3_d;
			low_speed_flag            <= slow_d;
		end
	end

	// ----------------------------------------------------------------
	// Terminal routing
	// ----------------------------------------------------------------
	logic [12:0] flags;

	// Same-cycle sources keep terminals in step with the flag outputs.
	assign flags = {slow_d, spd3_d, ofd3_d, spd2_d, ofd2_d, spd1_d, ofd1_d,
	                band_d, shut_d, alarm2_d, rev_d, fwd_d, regen_q};

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			terminal_out_q <= 7'h00;
		end else begin
			for (int i = 0; i < 7; i++) begin
				terminal_out_q[i] <=
					pick(terminal_function_codes[i*8 +: 8], flags);
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			changeover_relay_contact <= 1'b0;
		end else if (relay_assign_en) begin
			changeover_relay_contact <= pick(relay_function_code, flags);
		end else begin
			changeover_relay_contact <= alarm1_d;
		end
	end

endmodule

// >>> tb/dso_checker.sv
// Purpose: Timing checks on the status flags at the pins of dso_top.
// Assumes: Flags follow their inputs one cycle later, regen one more.
// Notes:   The regen hold is measured by a helper counter.
`timescale 1ns/100ps
module dso_checker #(
	parameter int unsigned REGEN_HOLD_CYC = 20
) (
	input wire logic        clock,                        // Clock
	input wire logic        arst_n,                       // Reset
	input wire logic [1:0]  control_method,               // Method
	input wire logic        drive_stopped,                // Stopped
	input wire logic        pre_excite,                   // Pre-excite
	input wire logic        dc_brake,                     // DC brake
	input wire logic        start_tuning,                 // Tuning
	input wire logic        alarm_stop,                   // Alarm stop
	input wire logic [4:0]  alarm_code,                   // Alarm kind
	input wire logic        reset_active,                 // Reset period
	input wire logic [15:0] output_freq,                  // Frequency
	input wire logic [15:0] detect_threshold_2,           // Threshold 2
	input wire logic [15:0] low_speed_threshold,          // Low speed
	input wire logic        regen_status_flag,            // Regen
	input wire logic        forward_rotation_flag,        // Forward
	input wire logic        reverse_rotation_flag,        // Reverse
	input wire logic        primary_alarm_flag,           // Alarm
	input wire logic        secondary_alarm_flag,         // Alarm 2
	input wire logic        input_contactor_shutoff_flag, // Shutoff
	input wire logic        at_target_frequency_flag,     // Up to freq
	input wire logic        output_freq_detect_flag_1,    // Freq 1
	input wire logic        output_freq_detect_flag_2,    // Freq 2
	input wire logic        speed_detect_flag_1,          // Speed 1
	input wire logic        low_speed_flag                // Low speed
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic        inh;
	logic        run_ok;
	logic        ge2;
	logic        lt_ls;
	logic [31:0] hi_cnt_q;
	logic        live_q;
	assign inh = dc_brake | pre_excite | start_tuning;
	assign run_ok = !drive_stopped && !pre_excite && control_method == 2'h3;
	assign ge2 = output_freq >= detect_threshold_2;
	assign lt_ls = output_freq < low_speed_threshold;
	// A wide counter, so a long hold never wraps into a false failure.
	// The edge that releases reset still finds the flags in reset, so level checks
	// on inputs start one edge later.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hi_cnt_q <= 32'h0;
			live_q   <= 1'b0;
		end else begin
			hi_cnt_q <= regen_status_flag ? hi_cnt_q + 32'h1 : 32'h0;
			live_q   <= 1'b1;
		end
	end
	sequence s_forced;
		(!run_ok) [*2];
	endsequence
	sequence s_reset_wait;
		reset_active && secondary_alarm_flag;
	endsequence
	a_regen_hold: assert property ($fell(regen_status_flag) && $past(run_ok) &&
		$past(run_ok, 2) |-> hi_cnt_q >= REGEN_HOLD_CYC) else $error("regen flag dropped early");
	a_regen_forced: assert property (s_forced |=> !regen_status_flag)
		else $error("regen flag not forced low");
	a_dir_off: assert property (drive_stopped || control_method != 2'h3 |=>
		!forward_rotation_flag && !reverse_rotation_flag) else $error("direction flag set");
	a_alarm_both: assert property (alarm_stop |=>
		primary_alarm_flag && secondary_alarm_flag) else $error("alarm flags missing");
	a_alarm2_reset: assert property (s_reset_wait |=> secondary_alarm_flag)
		else $error("alarm 2 cleared in reset");
	a_shutoff_class: assert property (alarm_stop && alarm_code >= 5'h01 &&
		alarm_code <= 5'h0B |=> input_contactor_shutoff_flag) else $error("shutoff missing");
	a_freq2_level: assert property (live_q && !inh && !drive_stopped |=>
		output_freq_detect_flag_2 == $past(ge2)) else $error("freq 2 flag wrong");
	a_low_speed: assert property (live_q && !inh && !drive_stopped |=>
		low_speed_flag == $past(lt_ls)) else $error("low speed flag wrong");
	a_pair_open: assert property (!control_method[1] && !inh && !drive_stopped |=>
		speed_detect_flag_1 == output_freq_detect_flag_1) else $error("flag pair split");
	a_inhibit_all: assert property (inh |=> !output_freq_detect_flag_1 &&
		!output_freq_detect_flag_2 && !speed_detect_flag_1 && !at_target_frequency_flag &&
		!low_speed_flag) else $error("flag set while inhibited");
endmodule
bind dso_top dso_checker #(.REGEN_HOLD_CYC(REGEN_HOLD_CYC)) u_chk (.*);

// >>> tb/dso_relay_sense.sv
// Purpose: Far-side controller that senses the terminals and relay.
// Assumes: The controller samples once per clock.
// Notes:   Adds one cycle, so readers must allow for it.
`timescale 1ns/100ps
module dso_relay_sense (
	input wire logic       clock,  // Clock
	input wire logic       arst_n, // Reset
	input wire logic [6:0] terms,  // Terminals
	input wire logic       relay,  // Relay contact
	output logic [7:0]     seen_q  // Sensed levels
);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			seen_q <= 8'h00;
		end else begin
			seen_q <= {relay, terms};
		end
	end
endmodule

// >>> tb/dso_top_tb_top.sv
// Purpose: Self-checking bench for dso_top.
// Assumes: Regen hold shortened to HOLD cycles.
// Notes:   Seed fixed, so every run is the same.
`timescale 1ns/100ps
`include "dso_defs.svh"
module dso_top_tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int unsigned HOLD = 20;
	localparam logic [7:0] CODES [13] = '{8'h01, 8'h04, 8'h05, 8'h06,
		8'h29, 8'h2A, 8'h2B, 8'h22, 8'h1E, 8'h1F, 8'h20, 8'h5B, 8'h5E};
	logic clock, arst_n, drive_stopped, pre_excite, dc_brake, start_tuning;
	logic regen_cond, reverse_dir, alarm_stop, reset_active, relay_assign_en;
	logic [1:0] control_method;
	logic [4:0] alarm_code;
	logic [6:0] target_band_percent, terminal_out_q;
	logic [7:0] relay_function_code, seen;
	logic [15:0] output_freq, set_freq, motor_speed, detect_threshold_1, a;
	logic [15:0] reverse_detect_threshold, detect_threshold_2, detect_threshold_3;
	logic [15:0] low_speed_threshold;
	logic [55:0] terminal_function_codes;
	logic changeover_relay_contact, regen_status_flag, forward_rotation_flag;
	logic reverse_rotation_flag, primary_alarm_flag, secondary_alarm_flag;
	logic input_contactor_shutoff_flag, at_target_frequency_flag, low_speed_flag;
	logic output_freq_detect_flag_1, output_freq_detect_flag_2, output_freq_detect_flag_3;
	logic speed_detect_flag_1, speed_detect_flag_2, speed_detect_flag_3;
	logic [12:0] ef;
	int fail_count, n_tests, seed;
	dso_top #(.REGEN_HOLD_CYC(HOLD)) u_dut (.*);
	dso_relay_sense u_sense (.clock(clock), .arst_n(arst_n), .terms(terminal_out_q),
		.relay(changeover_relay_contact), .seen_q(seen));
	always #4 clock = !clock;
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic s, input logic e, input int id);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t item %0d seen %b want %b", $time, id, s, e);
		end
	endtask
	function automatic logic [15:0] rf();
		return 16'(($random(seed) & 32'h7FFFFFFF) % 32'hFA1);
	endfunction
	function automatic logic t_exp(input logic [7:0] c);
		logic v;
		v = 1'h0;
		for (int k = 0; k < 13; k++) begin
			if (c == CODES[k]) v = ef[k];
			if (c == CODES[k] + 8'h64) v = !ef[k];
		end
		return v;
	endfunction
	task automatic calc();
		logic [15:0] sp;
		logic [15:0] t1;
		logic [31:0] d;
		logic        ok;
		logic        dv;
		sp = control_method[1] ? motor_speed : output_freq;
		t1 = (reverse_dir && reverse_detect_threshold !== `DSO_SAME_AS_FIRST) ?
			reverse_detect_threshold : detect_threshold_1;
		d = 32'(output_freq > set_freq ? output_freq - set_freq : set_freq - output_freq);
		ok = !(dc_brake | pre_excite | start_tuning);
		dv = control_method == 2'h3 && !drive_stopped && !pre_excite && motor_speed != 16'h0;
		ef[0] = ok && d * 32'h64 <= 32'(set_freq) * 32'(target_band_percent);
		ef[1] = ok && output_freq >= t1;
		ef[2] = ok && output_freq >= detect_threshold_2;
		ef[3] = ok && output_freq >= detect_threshold_3;
		ef[4] = ok && sp >= t1;
		ef[5] = ok && sp >= detect_threshold_2;
		ef[6] = ok && sp >= detect_threshold_3;
		ef[7] = ok && output_freq < low_speed_threshold;
		ef[8] = dv && !reverse_dir;
		ef[9] = dv && reverse_dir;
	endtask
	task automatic chk_all();
		logic [12:0] act;
		act = {secondary_alarm_flag, input_contactor_shutoff_flag, regen_status_flag,
			reverse_rotation_flag, forward_rotation_flag, low_speed_flag,
			speed_detect_flag_3, speed_detect_flag_2, speed_detect_flag_1,
			output_freq_detect_flag_3, output_freq_detect_flag_2,
			output_freq_detect_flag_1, at_target_frequency_flag};
		for (int k = 0; k < 13; k++)
			chk(act[k], ef[k], k);
		for (int t = 0; t < 7; t++)
			chk(seen[t], t_exp(terminal_function_codes[8*t+:8]), 20 + t);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		complete_run();
	end
	initial begin
		{clock, arst_n, drive_stopped, pre_excite, dc_brake, start_tuning} = '0;
		{regen_cond, reverse_dir, alarm_stop, reset_active, relay_assign_en} = '0;
		{control_method, alarm_code, target_band_percent, relay_function_code} = '0;
		{output_freq, set_freq, motor_speed, detect_threshold_1} = '0;
		{reverse_detect_threshold, detect_threshold_2, detect_threshold_3} = '0;
		low_speed_threshold = '0;
		terminal_function_codes = {7{8'h68}};
		ef = '0;
		seed = 4;
		step(3);
		for (int t = 0; t < 7; t++) chk(terminal_out_q[t], 1'h0, 30 + t);
		@(posedge clock);
		arst_n <= 1'h1;
		for (int i = 0; i < 60; i++) begin
			@(posedge clock);
			a = rf();
			detect_threshold_1 <= a;
			output_freq <= (i % 4 == 0) ? a : rf();
			set_freq <= rf();
			motor_speed <= rf();
			detect_threshold_2 <= rf();
			detect_threshold_3 <= rf();
			low_speed_threshold <= rf();
			reverse_detect_threshold <= (i % 3 == 0) ? `DSO_SAME_AS_FIRST : rf();
			target_band_percent <= 7'(($random(seed) & 32'h7F) % 32'h65);
			control_method <= 2'($random(seed));
			reverse_dir <= 1'($random(seed));
			dc_brake <= i % 7 == 3;
			pre_excite <= i % 7 == 5;
			start_tuning <= i % 7 == 6;
			for (int t = 0; t < 7; t++)
				terminal_function_codes[8*t+:8] <= CODES[($random(seed) & 32'hFF) % 32'hA]
					+ (($random(seed) & 32'h1) != 0 ? 8'h64 : 8'h00);
			step(3);
			calc();
			chk_all();
		end
		$display("test random thresholds done");
		@(posedge clock);
		{dc_brake, pre_excite, start_tuning} <= '0;
		terminal_function_codes <= {8'hC8, 8'hBF, 8'h5B, 8'hC2, 8'h5E, 8'h84, 8'h20};
		for (int c = 0; c < 13; c++) begin
			@(posedge clock);
			alarm_code <= 5'(c);
			alarm_stop <= 1'h1;
			step(3);
			ef[11] = c >= 1 && c <= 11;
			ef[12] = 1'h1;
			calc();
			chk_all();
			chk(primary_alarm_flag, 1'h1, 40);
			chk(seen[7], 1'h1, 41);
			@(posedge clock);
			alarm_stop <= 1'h0;
			reset_active <= 1'h1;
			step(4);
			chk(secondary_alarm_flag, 1'h1, 42);
			@(posedge clock);
			reset_active <= 1'h0;
			step(3);
			chk(secondary_alarm_flag, 1'h0, 43);
			chk(seen[7], 1'h0, 44);
		end
		ef[12:11] = 2'h0;
		$display("test alarms done");
		@(posedge clock);
		control_method <= 2'h3;
		regen_cond <= 1'h1;
		@(posedge clock);
		regen_cond <= 1'h0;
		step(HOLD / 2);
		chk(regen_status_flag, 1'h1, 50);
		chk(seen[0], 1'h1, 51);
		chk(seen[1], 1'h0, 52);
		step(HOLD + 4);
		chk(regen_status_flag, 1'h0, 53);
		@(posedge clock);
		regen_cond <= 1'h1;
		step(4);
		chk(regen_status_flag, 1'h1, 54);
		@(posedge clock);
		drive_stopped <= 1'h1;
		motor_speed <= 16'h0100;
		step(3);
		chk(regen_status_flag, 1'h0, 55);
		chk(forward_rotation_flag | reverse_rotation_flag, 1'h0, 56);
		@(posedge clock);
		drive_stopped <= 1'h0;
		control_method <= 2'h0;
		step(4);
		chk(regen_status_flag, 1'h0, 57);
		@(posedge clock);
		relay_assign_en <= 1'h1;
		relay_function_code <= 8'h5E;
		alarm_stop <= 1'h1;
		step(3);
		chk(seen[7], 1'h1, 58);
		$display("test regen and relay done");
		complete_run();
	end
endmodule
